// [asfl_pkg.sv]
// Shared constants and types for the converter status flag block.
package asfl_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte addresses.
	localparam logic [31:0] ADDR_STATUS     = 32'hffff0500;
	localparam logic [31:0] ADDR_MASK       = 32'hffff0504;
	localparam logic [31:0] ADDR_MODE       = 32'hffff0508;
	localparam logic [31:0] ADDR_FILTER     = 32'hffff050c;
	localparam logic [31:0] ADDR_CHAN_CTRL  = 32'hffff0510;
	localparam logic [31:0] ADDR_CONFIG     = 32'hffff0514;
	localparam logic [31:0] ADDR_THRESHOLD  = 32'hffff0518;
	localparam logic [31:0] ADDR_CUR_RESULT = 32'hffff051c;
	localparam logic [31:0] ADDR_VT_RESULT  = 32'hffff0520;

	////////////////////////////////////////////////////////////////////////////////
	// Status word bit positions.
	localparam int BIT_CAL_DONE = 15;
	localparam int BIT_VT_ERR   = 13;
	localparam int BIT_CUR_ERR  = 12;
	localparam int BIT_CONT     = 5;
	localparam int BIT_CMP      = 4;
	localparam int BIT_TEMP_RDY = 2;
	localparam int BIT_VOLT_RDY = 1;
	localparam int BIT_CUR_RDY  = 0;

	// Control field positions.
	localparam int MODE_CONT_EN = 5;
	localparam int CFG_CMP_EN   = 0;
	localparam int CFG_VOLT_EN  = 1;
	localparam int CFG_TEMP_EN  = 2;
	localparam int CTRL_CUR_EN  = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Values after reset and fixed codes.
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam logic [7:0]  MASK_RESET   = 8'h00;
	localparam logic [7:0]  MODE_RESET   = 8'h00;
	localparam logic [15:0] FILTER_RESET = 16'h0000;
	localparam logic [15:0] CTRL_RESET   = 16'h0000;
	localparam logic [7:0]  CFG_RESET    = 8'h00;
	localparam logic [15:0] THRESH_RESET = 16'h0000;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	localparam logic [15:0] POS_FULL     = 16'h7fff;
	localparam logic [15:0] NEG_FULL     = 16'h8000;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	// One conversion as delivered by a modulator and filter chain.
	typedef struct packed {
		logic        valid;
		logic        settled;
		logic        over;
		logic        under;
		logic [15:0] data;
	} asfl_conv_t;

endpackage

// [asfl_status_flags.sv]
// Converter status flags, result registers and their AXI4-Lite register bank.
//
// Notes on behaviour
// R1 - Calibration finishing sets the calibration-done flag, bit 15.
// R2 - Writing mode, filter or current channel control clears bit 15.
// R3 - An over or underrange voltage/temperature conversion sets bit 13.
// R4 - Out-of-range results are stored clamped to negative or positive full scale.
// R5 - An in-range voltage/temperature result stored clears bit 13.
// R6 - An over or underrange current conversion sets bit 12.
// R7 - An in-range current result stored clears bit 12.
// R8 - Software ignores reserved bits 14, 11 to 6 and 3.
// R9 - Every current conversion sets continuous bit 5, settled or not.
// R10 - Bit 5 works only while its mode enable is set, else clear.
// R11 - Comparator bit 4 is meaningful only with the comparator enabled.
// R12 - Current magnitude above the threshold register sets bit 4.
// R13 - Any software reconfiguration clears bit 4.
// R14 - A valid temperature result stored sets bit 2 when enabled.
// R15 - A valid voltage result stored sets bit 1 when enabled.
// R16 - A valid current result stored sets bit 0 when enabled.
// R17 - End of calibration also sets bits 0, 1 and 2.
// R18 - Reading either result register clears bits 2 and 1.
// R19 - Reading the current result register clears bits 0 and 5.
// R20 - Status word is read-only and resets to zero.
// R21 - Masked bits 7 to 0 are ORed into one interrupt; upper bits never.
// R22 - Result registers hold until ready flags clear, unless core powered down.
// R23 - With current channel off, reading the other result clears all ready flags.
// R24 - A set and a clear in the same cycle leave the flag set.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps

module asfl_status_flags (
	input  wire logic                CLK,               // System clock, 25 MHz.
	input  wire logic                RST_N,             // Synchronous reset, active low.
	input  wire asfl_pkg::asfl_conv_t I_CONV,           // Current channel conversion.
	input  wire asfl_pkg::asfl_conv_t VT_CONV,          // Voltage/temperature conversion.
	input  wire logic                VT_IS_TEMP,        // VT_CONV carries a temperature.
	input  wire logic                CAL_DONE,          // Calibration finished pulse.
	input  wire logic                CORE_POWERED_DOWN, // Processor core is powered down.
	input  wire logic [31:0]         AWADDR,            // Write address.
	input  wire logic                AWVALID,           // Write address valid.
	output logic                     AWREADY,           // Write address ready.
	input  wire logic [31:0]         WDATA,             // Write data.
	input  wire logic [3:0]          WSTRB,             // Write byte strobes.
	input  wire logic                WVALID,            // Write data valid.
	output logic                     WREADY,            // Write data ready.
	output logic [1:0]               BRESP,             // Write response.
	output logic                     BVALID,            // Write response valid.
	input  wire logic                BREADY,            // Write response ready.
	input  wire logic [31:0]         ARADDR,            // Read address.
	input  wire logic                ARVALID,           // Read address valid.
	output logic                     ARREADY,           // Read address ready.
	output logic [31:0]              RDATA,             // Read data.
	output logic [1:0]               RRESP,             // Read response.
	output logic                     RVALID,            // Read data valid.
	input  wire logic                RREADY,            // Read data ready.
	output logic                     IRQ                // Masked converter interrupt.
);

	////////////////////////////////////////////////////////////////////////////////
	// Helpers.

	// A hardware set always beats a clear landing in the same cycle.
	function automatic logic flag_next(input logic cur, input logic set, input logic clr);
		return set | (cur & ~clr); // [R24]
	endfunction

	function automatic logic [15:0] clamp(input asfl_pkg::asfl_conv_t c);
		logic [15:0] r;
		r = c.data;
		if (c.under) begin
			r = asfl_pkg::NEG_FULL; // [R4]
		end else if (c.over) begin
			r = asfl_pkg::POS_FULL; // [R4]
		end
		return r;
	endfunction

	// Two's complement magnitude; the most negative code maps to 16'h8000 unsigned.
	function automatic logic [15:0] magnitude(input logic [15:0] v);
		return v[15] ? 16'((~v) + 16'h0001) : v;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// State.

	logic        cal_done;
	logic        vt_err;
	logic        cur_err;
	logic        cont;
	logic        cmp;
	logic        temp_rdy;
	logic        volt_rdy;
	logic        cur_rdy;
	logic [7:0]  mask;
	logic [7:0]  mode;
	logic [15:0] filter;
	logic [15:0] chan_ctrl;
	logic [7:0]  config_reg;
	logic [15:0] threshold;
	logic [15:0] cur_result;
	logic [15:0] vt_result;
	logic        aw_held;
	logic        w_held;
	logic [31:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	////////////////////////////////////////////////////////////////////////////////
	// Bus handshakes and decode.

	wire aw_take   = AWVALID & AWREADY;
	wire w_take    = WVALID & WREADY;
	wire wr_commit = aw_held & w_held & ~BVALID;
	wire ar_take   = ARVALID & ARREADY;

	wire wr_mask   = wr_commit & (aw_addr == asfl_pkg::ADDR_MASK);
	wire wr_mode   = wr_commit & (aw_addr == asfl_pkg::ADDR_MODE);
	wire wr_filter = wr_commit & (aw_addr == asfl_pkg::ADDR_FILTER);
	wire wr_ctrl   = wr_commit & (aw_addr == asfl_pkg::ADDR_CHAN_CTRL);
	wire wr_config = wr_commit & (aw_addr == asfl_pkg::ADDR_CONFIG);
	wire wr_thresh = wr_commit & (aw_addr == asfl_pkg::ADDR_THRESHOLD);
	wire wr_ok     = wr_mask | wr_mode | wr_filter | wr_ctrl | wr_config | wr_thresh;

	wire rd_cur = ar_take & (ARADDR == asfl_pkg::ADDR_CUR_RESULT);
	wire rd_vt  = ar_take & (ARADDR == asfl_pkg::ADDR_VT_RESULT);

	// Reserved bits stay zero and nothing but flags drives the word.
	wire [15:0] status = {cal_done, 1'b0, vt_err, cur_err, 6'h00, cont, cmp, 1'b0,
		temp_rdy, volt_rdy, cur_rdy}; // [R8] [R20]

	logic [31:0] rd_sel;
	logic        rd_hit;
	always_comb begin
		rd_sel = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case (ARADDR)
			asfl_pkg::ADDR_STATUS:     rd_sel = {16'h0000, status};
			asfl_pkg::ADDR_MASK:       rd_sel = {24'h000000, mask};
			asfl_pkg::ADDR_MODE:       rd_sel = {24'h000000, mode};
			asfl_pkg::ADDR_FILTER:     rd_sel = {16'h0000, filter};
			asfl_pkg::ADDR_CHAN_CTRL:  rd_sel = {16'h0000, chan_ctrl};
			asfl_pkg::ADDR_CONFIG:     rd_sel = {24'h000000, config_reg};
			asfl_pkg::ADDR_THRESHOLD:  rd_sel = {16'h0000, threshold};
			asfl_pkg::ADDR_CUR_RESULT: rd_sel = {16'h0000, cur_result};
			asfl_pkg::ADDR_VT_RESULT:  rd_sel = {16'h0000, vt_result};
			default:                   rd_hit = 1'b0;
		endcase
	end

	wire [31:0] wr_merged_mask   = merge({24'h000000, mask}, w_data, w_strb);
	wire [31:0] wr_merged_mode   = merge({24'h000000, mode}, w_data, w_strb);
	wire [31:0] wr_merged_filter = merge({16'h0000, filter}, w_data, w_strb);
	wire [31:0] wr_merged_ctrl   = merge({16'h0000, chan_ctrl}, w_data, w_strb);
	wire [31:0] wr_merged_cfg    = merge({24'h000000, config_reg}, w_data, w_strb);
	wire [31:0] wr_merged_thresh = merge({16'h0000, threshold}, w_data, w_strb);

	////////////////////////////////////////////////////////////////////////////////
	// Converter events.

	wire cont_en = mode[asfl_pkg::MODE_CONT_EN];
	wire cmp_en  = config_reg[asfl_pkg::CFG_CMP_EN];
	wire volt_en = config_reg[asfl_pkg::CFG_VOLT_EN];
	wire temp_en = config_reg[asfl_pkg::CFG_TEMP_EN];
	wire cur_en  = chan_ctrl[asfl_pkg::CTRL_CUR_EN];

	wire [15:0] cur_clamped = clamp(I_CONV);
	wire [15:0] vt_clamped  = clamp(VT_CONV);
	wire        cur_out     = I_CONV.over | I_CONV.under;
	wire        vt_out      = VT_CONV.over | VT_CONV.under;

	// Unread results are protected unless the core sleeps and nobody can read them.
	wire cur_load = I_CONV.valid & (~cur_rdy | CORE_POWERED_DOWN); // [R22]
	wire vt_load  = VT_CONV.valid & ((~volt_rdy & ~temp_rdy) | CORE_POWERED_DOWN); // [R22]

	wire cur_good  = cur_load & I_CONV.settled;
	wire vt_good   = vt_load & VT_CONV.settled;
	wire cmp_over  = magnitude(cur_clamped) > threshold;
	wire reconfig  = wr_mode | wr_filter | wr_ctrl; // [R2]
	wire reconf_ct = reconfig | wr_config | wr_thresh; // [R13]

	wire set_cal   = CAL_DONE; // [R1]
	wire set_vterr = VT_CONV.valid & vt_out; // [R3]
	wire clr_vterr = vt_load & ~vt_out; // [R5]
	wire set_ierr  = I_CONV.valid & cur_out; // [R6]
	wire clr_ierr  = cur_load & ~cur_out; // [R7]
	wire set_cont  = I_CONV.valid & cont_en; // [R9] [R10]
	wire clr_cont  = rd_cur | ~cont_en; // [R19] [R10]
	wire set_cmp   = I_CONV.valid & cmp_en & cmp_over; // [R12] [R11]
	wire clr_cmp   = reconf_ct | ~cmp_en; // [R13] [R11]
	wire set_trdy  = (vt_good & temp_en & VT_IS_TEMP) | CAL_DONE; // [R14] [R17]
	wire set_vrdy  = (vt_good & volt_en & ~VT_IS_TEMP) | CAL_DONE; // [R15] [R17]
	wire set_irdy  = (cur_good & cur_en) | CAL_DONE; // [R16] [R17]
	wire clr_vtrdy = rd_cur | rd_vt; // [R18]
	wire clr_irdy  = rd_cur | (rd_vt & ~cur_en); // [R19] [R23]

	////////////////////////////////////////////////////////////////////////////////
	// Status flags.

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			{cal_done, vt_err, cur_err} <= 3'h0; // [R20]
			{cont, cmp, temp_rdy, volt_rdy, cur_rdy} <= 5'h00;
		end else begin
			cal_done <= flag_next(cal_done, set_cal, reconfig);
			vt_err   <= flag_next(vt_err, set_vterr, clr_vterr);
			cur_err  <= flag_next(cur_err, set_ierr, clr_ierr);
			cont     <= flag_next(cont, set_cont, clr_cont);
			cmp      <= flag_next(cmp, set_cmp, clr_cmp);
			temp_rdy <= flag_next(temp_rdy, set_trdy, clr_vtrdy);
			volt_rdy <= flag_next(volt_rdy, set_vrdy, clr_vtrdy);
			cur_rdy  <= flag_next(cur_rdy, set_irdy, clr_irdy);
		end
	end

	// Only the lower byte may interrupt; flags above it are for polling.
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(status[7:0] & mask); // [R21]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Result registers.

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			cur_result <= asfl_pkg::RESULT_RESET;
			vt_result  <= asfl_pkg::RESULT_RESET;
		end else begin
			if (cur_load) begin
				cur_result <= cur_clamped; // [R4]
			end
			if (vt_load) begin
				vt_result <= vt_clamped; // [R4]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control registers.

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			mask       <= asfl_pkg::MASK_RESET;
			mode       <= asfl_pkg::MODE_RESET;
			filter     <= asfl_pkg::FILTER_RESET;
			chan_ctrl  <= asfl_pkg::CTRL_RESET;
			config_reg <= asfl_pkg::CFG_RESET;
			threshold  <= asfl_pkg::THRESH_RESET;
		end else begin
			if (wr_mask) begin
				mask <= wr_merged_mask[7:0];
			end
			if (wr_mode) begin
				mode <= wr_merged_mode[7:0];
			end
			if (wr_filter) begin
				filter <= wr_merged_filter[15:0];
			end
			if (wr_ctrl) begin
				chan_ctrl <= wr_merged_ctrl[15:0];
			end
			if (wr_config) begin
				config_reg <= wr_merged_cfg[7:0];
			end
			if (wr_thresh) begin
				threshold <= wr_merged_thresh[15:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Write channel: address and data are caught separately, in either order.

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 32'h0000_0000;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
			AWREADY <= 1'b0;
			WREADY  <= 1'b0;
		end else begin
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_addr <= AWADDR;
			end else if (wr_commit) begin
				aw_held <= 1'b0;
			end
			if (w_take) begin
				w_held <= 1'b1;
				w_data <= WDATA;
				w_strb <= WSTRB;
			end else if (wr_commit) begin
				w_held <= 1'b0;
			end
			AWREADY <= ~aw_take & ~aw_held & ~BVALID;
			WREADY  <= ~w_take & ~w_held & ~BVALID;
		end
	end

	// Writes to read-only or unmapped words change nothing and answer with an error.
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			BVALID <= 1'b0;
			BRESP  <= asfl_pkg::RESP_OKAY;
		end else begin
			if (wr_commit) begin
				BVALID <= 1'b1;
				BRESP  <= wr_ok ? asfl_pkg::RESP_OKAY : asfl_pkg::RESP_SLVERR; // [R20]
			end else if (BVALID & BREADY) begin
				BVALID <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read channel: read side effects happen on the address handshake.

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ARREADY <= 1'b0;
			RVALID  <= 1'b0;
			RDATA   <= 32'h0000_0000;
			RRESP   <= asfl_pkg::RESP_OKAY;
		end else begin
			if (ar_take) begin
				ARREADY <= 1'b0;
				RVALID  <= 1'b1;
				RDATA   <= rd_sel;
				RRESP   <= rd_hit ? asfl_pkg::RESP_OKAY : asfl_pkg::RESP_SLVERR;
			end else begin
				if (RVALID & RREADY) begin
					RVALID <= 1'b0;
				end
				ARREADY <= ~RVALID | RREADY;
			end
		end
	end

endmodule

// [asfl_status_flags_props.sv]
// Concurrent checks on the ports of the converter status flag block.
`timescale 1ns/1ps

module asfl_status_flags_props (
	input wire logic        CLK,     // System clock.
	input wire logic        RST_N,   // Synchronous reset, active low.
	input wire logic        AWVALID, // Write address valid.
	input wire logic        AWREADY, // Write address ready.
	input wire logic        WVALID,  // Write data valid.
	input wire logic        WREADY,  // Write data ready.
	input wire logic        BVALID,  // Write response valid.
	input wire logic        BREADY,  // Write response ready.
	input wire logic [1:0]  BRESP,   // Write response.
	input wire logic [31:0] ARADDR,  // Read address.
	input wire logic        ARVALID, // Read address valid.
	input wire logic        ARREADY, // Read address ready.
	input wire logic        RVALID,  // Read data valid.
	input wire logic        RREADY,  // Read data ready.
	input wire logic [31:0] RDATA,   // Read data.
	input wire logic [1:0]  RRESP,   // Read response.
	input wire logic        IRQ      // Interrupt.
);
	////////////////////////////////////////////////////////////////////////////////
	// Reset is checked without a disable so the quiet outputs during reset are seen.
	chk_reset_quiet: assert property (@(posedge CLK) !RST_N |=> !RVALID && !BVALID && !IRQ && !ARREADY) else $error("outputs active in reset");
	chk_rd_answer: assert property (@(posedge CLK) disable iff (!RST_N) ARVALID && ARREADY |=> RVALID) else $error("read answer late");
	chk_rd_hold: assert property (@(posedge CLK) disable iff (!RST_N) RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP)) else $error("read data dropped");
	chk_wr_hold: assert property (@(posedge CLK) disable iff (!RST_N) BVALID && !BREADY |=> BVALID && $stable(BRESP)) else $error("write response dropped");
	chk_ar_refuse: assert property (@(posedge CLK) disable iff (!RST_N) RVALID && !RREADY |-> !ARREADY) else $error("address taken while busy");
	chk_wr_refuse: assert property (@(posedge CLK) disable iff (!RST_N) BVALID |-> !AWREADY && !WREADY) else $error("write taken while busy");
	chk_wr_answer: assert property (@(posedge CLK) disable iff (!RST_N) AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID) else $error("write answer late");
	chk_status_word: assert property (@(posedge CLK) disable iff (!RST_N) ARVALID && ARREADY && ARADDR == asfl_pkg::ADDR_STATUS |=> RRESP == asfl_pkg::RESP_OKAY && RDATA[31:16] == 16'h0000) else $error("status read wrong");
	chk_unmapped_rd: assert property (@(posedge CLK) disable iff (!RST_N) ARVALID && ARREADY && ARADDR == 32'hffff0600 |=> RRESP == asfl_pkg::RESP_SLVERR && RDATA == 32'h00000000) else $error("unmapped read wrong");
endmodule

bind asfl_status_flags asfl_status_flags_props u_props (.CLK, .RST_N, .AWVALID, .AWREADY, .WVALID,
	.WREADY, .BVALID, .BREADY, .BRESP, .ARADDR, .ARVALID, .ARREADY, .RVALID, .RREADY, .RDATA,
	.RRESP, .IRQ);

// [testbench.sv]
// Self-checking bench for the converter status flag block.
`timescale 1ns/1ps

module testbench;
	logic                 clk = 1'b0, rst_n = 1'b0, tmp = 1'b0, cal = 1'b0, cpd = 1'b0;
	asfl_pkg::asfl_conv_t i_conv = '0, vt_conv = '0;
	logic [31:0]          awaddr = '0, wdata = '0, araddr = '0, rdata, st;
	logic [3:0]           wstrb = 4'hf;
	logic                 awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
	logic                 rready = 1'b0, awready, wready, bvalid, arready, rvalid, irq, ov, un, cm;
	logic [1:0]           bresp, rresp;
	logic [15:0]          d, thr, cv;
	int                   n_errors = 0, samples_checked = 0, i;
	// Status bits with a defined meaning; reserved bits are not compared.
	localparam logic [31:0] SM = 32'h0000b037;

	asfl_status_flags u_asfl_status_flags (.CLK(clk), .RST_N(rst_n), .I_CONV(i_conv),
		.VT_CONV(vt_conv), .VT_IS_TEMP(tmp), .CAL_DONE(cal), .CORE_POWERED_DOWN(cpd),
		.AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
		.WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
		.ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
		.RVALID(rvalid), .RREADY(rready), .IRQ(irq));

	initial begin
		forever #20 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Handshakes are judged at the falling edge, where the ready flops are settled.
	task automatic wr(input logic [31:0] a, v, input logic [1:0] er = asfl_pkg::RESP_OKAY);
		logic ha, hw, hb;
		logic [1:0] r;
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge clk);
			ha = awvalid && awready;
			hw = wvalid && wready;
			hb = bvalid;
			r = bresp;
			@(posedge clk);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
			if (hb) break;
		end
		bready <= 1'b0;
		if (n == 50) begin
			n_errors++;
			end_sim();
		end
		chk({30'h0, r}, {30'h0, er});
	endtask

	task automatic rd(input logic [31:0] a, output logic [31:0] v,
			input logic [1:0] er = asfl_pkg::RESP_OKAY);
		logic ha, hr;
		logic [1:0] r;
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge clk);
			ha = arvalid && arready;
			hr = rvalid;
			v = rdata;
			r = rresp;
			@(posedge clk);
			if (ha) arvalid <= 1'b0;
			if (hr) break;
		end
		rready <= 1'b0;
		if (n == 50) begin
			n_errors++;
			end_sim();
		end
		chk({30'h0, r}, {30'h0, er});
	endtask

	task automatic rs(input logic [31:0] m, e);
		rd(asfl_pkg::ADDR_STATUS, st);
		chk(st & m, e);
	endtask

	// One-cycle event pulse on the converter side.
	task automatic fire(input asfl_pkg::asfl_conv_t ci, cvt, input logic t, c);
		@(posedge clk);
		i_conv <= ci;
		vt_conv <= cvt;
		tmp <= t;
		cal <= c;
		@(posedge clk);
		i_conv <= '0;
		vt_conv <= '0;
		cal <= 1'b0;
	endtask

	function automatic asfl_pkg::asfl_conv_t mk(input logic [15:0] v, input logic o, u);
		return '{valid: 1'b1, settled: 1'b1, over: o, under: u, data: v};
	endfunction

	function automatic logic [15:0] clamp(input logic [15:0] v, input logic o, u);
		return u ? asfl_pkg::NEG_FULL : (o ? asfl_pkg::POS_FULL : v);
	endfunction

	function automatic logic [16:0] mag(input logic [15:0] v);
		return v[15] ? 17'h10000 - {1'b0, v} : {1'b0, v};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] cfg[3];
		asfl_pkg::asfl_conv_t c;
		cfg = '{asfl_pkg::ADDR_MODE, asfl_pkg::ADDR_FILTER, asfl_pkg::ADDR_CHAN_CTRL};
		void'($urandom(79));
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rs(32'hffffffff, 32'h0);
		rd(asfl_pkg::ADDR_MASK, st);
		chk(st, 32'h0);
		wr(asfl_pkg::ADDR_STATUS, 32'hffff, asfl_pkg::RESP_SLVERR);
		rs(32'hffffffff, 32'h0);
		rd(32'hffff0600, st, asfl_pkg::RESP_SLVERR);
		chk(st, 32'h0);
		$display("test reset done");
		for (i = 0; i < 3; i++) begin
			fire('0, '0, 1'b0, 1'b1);
			rs(SM, 32'h8007);
			wr(cfg[i], 32'h0);
			rs(SM, 32'h0007);
			rd(asfl_pkg::ADDR_CUR_RESULT, st);
			rs(SM, 32'h0);
		end
		$display("test calibration done");
		wr(asfl_pkg::ADDR_MASK, 32'h7);
		fire('0, '0, 1'b0, 1'b1);
		@(posedge clk);
		@(negedge clk);
		chk({31'h0, irq}, 32'h1);
		wr(asfl_pkg::ADDR_MASK, 32'hff);
		rd(asfl_pkg::ADDR_CUR_RESULT, st);
		@(negedge clk);
		chk({31'h0, irq}, 32'h0);
		$display("test interrupt done");
		wr(asfl_pkg::ADDR_CHAN_CTRL, 32'h1);
		for (i = 0; i < 8; i++) begin
			ov = (i == 2 || i == 5);
			un = (i == 3 || i == 5);
			d = 16'($urandom);
			cv = clamp(d, ov, un);
			thr = (i == 4) ? 16'(mag(cv)) : 16'($urandom);
			wr(asfl_pkg::ADDR_MODE, {26'h0, i[0], 5'h0});
			wr(asfl_pkg::ADDR_CONFIG, {31'h0, i != 7});
			wr(asfl_pkg::ADDR_THRESHOLD, {16'h0, thr});
			fire(mk(d, ov, un), '0, 1'b0, 1'b0);
			cm = (i != 7) && (mag(cv) > {1'b0, thr});
			rs(SM, {19'h0, ov | un, 6'h0, i[0], cm, 4'h1});
			rd(asfl_pkg::ADDR_CUR_RESULT, st);
			chk(st, {16'h0, cv});
			rs(SM, {19'h0, ov | un, 7'h0, cm, 4'h0});
		end
		// A raised comparator flag must drop on a write that touches no comparator field.
		wr(asfl_pkg::ADDR_CONFIG, 32'h1);
		wr(asfl_pkg::ADDR_THRESHOLD, 32'h0);
		fire(mk(16'h0100, 1'b0, 1'b0), '0, 1'b0, 1'b0);
		rs(32'h10, 32'h10);
		wr(asfl_pkg::ADDR_FILTER, 32'h0);
		rs(32'h10, 32'h0);
		rd(asfl_pkg::ADDR_CUR_RESULT, st);
		wr(asfl_pkg::ADDR_CONFIG, 32'h0);
		c = mk(16'h0bad, 1'b0, 1'b0);
		c.settled = 1'b0;
		fire(c, '0, 1'b0, 1'b0);
		rs(SM, 32'h0020);
		rd(asfl_pkg::ADDR_CUR_RESULT, st);
		fire(mk(16'h1234, 1'b0, 1'b0), '0, 1'b0, 1'b0);
		fire(mk(16'h0456, 1'b0, 1'b0), '0, 1'b0, 1'b0);
		rd(asfl_pkg::ADDR_CUR_RESULT, st);
		chk(st, 32'h1234);
		cpd <= 1'b1;
		fire(mk(16'h1234, 1'b0, 1'b0), '0, 1'b0, 1'b0);
		fire(mk(16'h0456, 1'b0, 1'b0), '0, 1'b0, 1'b0);
		rd(asfl_pkg::ADDR_CUR_RESULT, st);
		chk(st, 32'h0456);
		cpd <= 1'b0;
		$display("test current channel done");
		wr(asfl_pkg::ADDR_CONFIG, 32'h7);
		fire('0, mk(16'h1111, 1'b0, 1'b0), 1'b0, 1'b0);
		rs(SM, 32'h0002);
		rd(asfl_pkg::ADDR_VT_RESULT, st);
		chk(st, 32'h1111);
		rs(SM, 32'h0);
		fire('0, mk(16'h2222, 1'b0, 1'b0), 1'b1, 1'b0);
		rs(SM, 32'h0004);
		rd(asfl_pkg::ADDR_CUR_RESULT, st);
		rs(SM, 32'h0);
		fire('0, mk(16'h0100, 1'b1, 1'b0), 1'b0, 1'b0);
		rs(32'h2000, 32'h2000);
		rd(asfl_pkg::ADDR_VT_RESULT, st);
		chk(st, 32'h7fff);
		fire('0, mk(16'h0200, 1'b0, 1'b0), 1'b0, 1'b0);
		rs(32'h2000, 32'h0);
		wr(asfl_pkg::ADDR_CHAN_CTRL, 32'h0);
		fire('0, '0, 1'b0, 1'b1);
		rd(asfl_pkg::ADDR_VT_RESULT, st);
		rs(32'h7, 32'h0);
		$display("test voltage channel done");
		// The read handshake and the calibration pulse land on the same edge.
		fork
			begin
				rd(asfl_pkg::ADDR_CUR_RESULT, st);
			end
			begin
				fire('0, '0, 1'b0, 1'b1);
			end
		join
		rs(32'h7, 32'h7);
		$display("test set wins done");
		end_sim();
	end
endmodule
